// ### fpcs_pkg.sv
// package: encodings, field positions and types for the fp control/status registers
package fpcs_pkg;
  localparam logic [1:0] SYS_OP0 = 2'h3;
  localparam logic [2:0] SYS_OP1 = 3'h3;
  localparam logic [3:0] SYS_CRN = 4'h4;
  localparam logic [3:0] SYS_CRM = 4'h4;
  localparam logic [2:0] OP2_CTRL = 3'h0;
  localparam logic [2:0] OP2_STAT = 3'h1;
  localparam int HALF_FZ_POS = 19;
  localparam int SAT_POS = 27;
  localparam int DENORM_POS = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] STAT_RESET = 32'h0000_0000;
  // writable bits: control 26..22 and 19; status 27, 7 and 4..0
  localparam logic [31:0] CTRL_WMASK = 32'h07C8_0000;
  localparam logic [31:0] STAT_WMASK = 32'h0800_009F;

  typedef struct packed {
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } fpcs_enc_s;

  // event flags from the datapath, one-cycle pulses
  typedef struct packed {
    logic saturation;
    logic denormal_input;
    logic inexact;
    logic underflow;
    logic overflow;
    logic divide_zero;
    logic invalid_op;
  } fpcs_evt_s;
endpackage

// ### fpcs_regs.sv
// fp control and status register pair behind the system register port
// Function
// (RL1) control bit 19 is the half-precision flush-to-zero control
// (RL2) bit 19 zero means IEEE compliant, one enables flush; resets to zero
// (RL3) encoding 11/011/0100/0100/000 selects the control register
// (RL4) encoding 11/011/0100/0100/001 selects the status register
// (RL5) both registers readable and writable at every exception level
// (RL6) status register is 32 bits wide
// (RL7) status bits 31..28 read zero; comparisons update condition flags instead
// (RL8) status bit 27 sets on SIMD saturation, holds until software writes zero
// (RL9) status bit 7 sets on input denormal, holds until written zero
// (RL10) status bit 4 sets on inexact, holds until written zero
// (RL11) status bit 3 sets on underflow, holds until written zero
// (RL12) status bit 2 sets on overflow, holds until written zero
// (RL13) status bit 1 sets on divide by zero, holds until written zero
// (RL14) status bit 0 sets on invalid operation, holds until written zero
// (RL15) both registers clear on reset; reserved bits read zero, ignore writes
// (RL16) a datapath event in the same cycle as a write wins over it
`timescale 1ns/1ps
module fpcs_regs
  import fpcs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sys_req_i,
  input wire logic sys_write_i,
  input wire fpcs_enc_s sys_enc_i,
  input wire logic [31:0] sys_wdata_i,
  input wire fpcs_evt_s evt_i,
  output logic [31:0] sys_rdata_o,
  output logic sys_hit_o,
  output logic [31:0] fp_control_o,
  output logic half_flush_zero_o
);
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic [31:0] stat_ff;
  logic [31:0] nxt_stat;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic hit_ff;
  logic nxt_hit;
  logic hfz_ff;
  logic nxt_hfz;
  logic sel_ctrl;
  logic sel_stat;
  logic [31:0] evt_bits;

  function automatic logic enc_match(input fpcs_enc_s e, input logic [2:0] op2);
    enc_match = (e.op0 == SYS_OP0) && (e.op1 == SYS_OP1) && (e.crn == SYS_CRN) &&
                (e.crm == SYS_CRM) && (e.op2 == op2);
  endfunction

  // no exception-level input: access is never refused by privilege
  assign sel_ctrl = sys_req_i && enc_match(sys_enc_i, OP2_CTRL); // RL3 RL5
  assign sel_stat = sys_req_i && enc_match(sys_enc_i, OP2_STAT); // RL4 RL5

  always_comb begin
    evt_bits = 32'h0000_0000;
    evt_bits[SAT_POS] = evt_i.saturation; // RL8
    evt_bits[DENORM_POS] = evt_i.denormal_input; // RL9
    evt_bits[4] = evt_i.inexact; // RL10
    evt_bits[3] = evt_i.underflow; // RL11
    evt_bits[2] = evt_i.overflow; // RL12
    evt_bits[1] = evt_i.divide_zero; // RL13
    evt_bits[0] = evt_i.invalid_op; // RL14
  end

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_stat = stat_ff;
    if (sel_ctrl && sys_write_i) begin
      nxt_ctrl = sys_wdata_i & CTRL_WMASK; // RL15
    end
    if (sel_stat && sys_write_i) begin
      nxt_stat = sys_wdata_i & STAT_WMASK; // RL15 RL7
    end
    // set applied after the write so a same-cycle event survives
    nxt_stat = nxt_stat | (evt_bits & STAT_WMASK); // RL16 RL8 RL9 RL10 RL11 RL12 RL13 RL14
    nxt_hfz = nxt_ctrl[HALF_FZ_POS]; // RL1 RL2
    nxt_hit = sel_ctrl || sel_stat;
    nxt_rdata = 32'h0000_0000;
    if (sel_ctrl && !sys_write_i) begin
      nxt_rdata = ctrl_ff;
    end else if (sel_stat && !sys_write_i) begin
      nxt_rdata = stat_ff; // RL6
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_ff <= CTRL_RESET; // RL15 RL2
      stat_ff <= STAT_RESET; // RL15
      rdata_ff <= 32'h0000_0000;
      hit_ff <= 1'b0;
      hfz_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      stat_ff <= nxt_stat;
      rdata_ff <= nxt_rdata;
      hit_ff <= nxt_hit;
      hfz_ff <= nxt_hfz;
    end
  end

  assign sys_rdata_o = rdata_ff;
  assign sys_hit_o = hit_ff;
  assign fp_control_o = ctrl_ff;
  assign half_flush_zero_o = hfz_ff;

  stat_rsvd_a: assert property (@(posedge mclk_i) disable iff (reset_i) // RL7
    stat_ff[31:28] == 4'h0 && stat_ff[26:8] == 19'h0_0000 && stat_ff[6:5] == 2'h0)
    else $error("reserved status bits not zero");
  sat_set_a: assert property (@(posedge mclk_i) disable iff (reset_i) // RL8
    evt_i.saturation |=> stat_ff[SAT_POS])
    else $error("saturation flag not set");
  denorm_set_a: assert property (@(posedge mclk_i) disable iff (reset_i) // RL9
    evt_i.denormal_input |=> stat_ff[DENORM_POS])
    else $error("denormal flag not set");
  inexact_set_a: assert property (@(posedge mclk_i) disable iff (reset_i) // RL10
    evt_i.inexact |=> stat_ff[4])
    else $error("inexact flag not set");
  under_set_a: assert property (@(posedge mclk_i) disable iff (reset_i) // RL11
    evt_i.underflow |=> stat_ff[3])
    else $error("underflow flag not set");
  over_set_a: assert property (@(posedge mclk_i) disable iff (reset_i) // RL12
    evt_i.overflow |=> stat_ff[2])
    else $error("overflow flag not set");
  divzero_set_a: assert property (@(posedge mclk_i) disable iff (reset_i) // RL13
    evt_i.divide_zero |=> stat_ff[1])
    else $error("divide zero flag not set");
  invalid_set_a: assert property (@(posedge mclk_i) disable iff (reset_i) // RL14
    evt_i.invalid_op |=> stat_ff[0])
    else $error("invalid flag not set");
  sticky_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i) // RL14
    (stat_ff[0] && !(sel_stat && sys_write_i)) |=> stat_ff[0])
    else $error("sticky flag dropped without write");
  hfz_track_a: assert property (@(posedge mclk_i) disable iff (reset_i) // RL1
    sel_ctrl && sys_write_i |=> ##1 half_flush_zero_o == $past(sys_wdata_i[HALF_FZ_POS], 2))
    else $error("half flush control mismatch");
  ctrl_read_a: assert property (@(posedge mclk_i) disable iff (reset_i) // RL3
    sel_ctrl && !sys_write_i |=> sys_hit_o && sys_rdata_o == $past(ctrl_ff))
    else $error("control read wrong");
  stat_write_a: assert property (@(posedge mclk_i) disable iff (reset_i) // RL4
    sel_stat && sys_write_i && evt_bits == 32'h0000_0000 |=>
      stat_ff == ($past(sys_wdata_i) & STAT_WMASK))
    else $error("status write wrong");
endmodule

// ### fpcs_dp_model.sv
// datapath model: raises one-cycle exception event pulses
`timescale 1ns/1ps
module fpcs_dp_model
  import fpcs_pkg::*;
(
  input wire logic mclk_i,
  output fpcs_evt_s evt_o
);
  initial evt_o = '0;
  // driven between rising edges so the core samples a settled pulse
  task automatic pulse(input logic [6:0] kinds);
    evt_o = kinds;
    @(negedge mclk_i);
    evt_o = '0;
  endtask
endmodule

// ### tb.sv
// testbench: system register accesses and datapath events
`timescale 1ns/1ps
module tb;
  import fpcs_pkg::*;
  logic mclk_i = 0;
  logic reset_i = 1;
  logic sys_req_i = 0;
  logic sys_write_i = 0;
  fpcs_enc_s sys_enc_i = '0;
  logic [31:0] sys_wdata_i = '0;
  fpcs_evt_s evt_i;
  logic [31:0] sys_rdata_o;
  logic [31:0] fp_control_o;
  logic sys_hit_o;
  logic half_flush_zero_o;
  int mismatches = 0;
  int samples_checked = 0;
  always #5 mclk_i = ~mclk_i;
  fpcs_dp_model i_dp (.mclk_i(mclk_i), .evt_o(evt_i));
  fpcs_regs i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .sys_req_i(sys_req_i),
    .sys_write_i(sys_write_i), .sys_enc_i(sys_enc_i), .sys_wdata_i(sys_wdata_i),
    .evt_i(evt_i), .sys_rdata_o(sys_rdata_o), .sys_hit_o(sys_hit_o),
    .fp_control_o(fp_control_o), .half_flush_zero_o(half_flush_zero_o));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one request per call, answer checked in the following cycle
  task automatic acc(input logic w, input logic [2:0] op2, input logic [31:0] wd,
    input logic hit, input logic [31:0] rd);
    sys_req_i = 1;
    sys_write_i = w;
    sys_enc_i = '{SYS_OP0, SYS_OP1, SYS_CRN, SYS_CRM, op2};
    sys_wdata_i = wd;
    @(negedge mclk_i);
    chk("hit", {31'h0, hit}, {31'h0, sys_hit_o});
    chk("rdata", rd, sys_rdata_o);
    // let one edge pass idle so the next call never re-raises the request in this step
    sys_req_i = 0;
    @(negedge mclk_i);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    int p;
    repeat (12) @(negedge mclk_i);
    reset_i = 0;
    acc(0, OP2_CTRL, 0, 1, CTRL_RESET);
    acc(0, OP2_STAT, 0, 1, STAT_RESET);
    $display("test reset values done");
    acc(1, OP2_CTRL, 32'hFFFF_FFFF, 1, 32'h0000_0000);
    chk("control", 32'h07C8_0000, fp_control_o);
    @(negedge mclk_i);
    chk("half_fz", 32'h1, {31'h0, half_flush_zero_o});
    acc(0, OP2_CTRL, 0, 1, 32'h07C8_0000);
    acc(1, OP2_CTRL, 32'h0000_0000, 1, 32'h0000_0000);
    @(negedge mclk_i);
    chk("half_fz", 32'h0, {31'h0, half_flush_zero_o});
    $display("test control done");
    acc(1, OP2_STAT, 32'hFFFF_FFFF, 1, 32'h0000_0000);
    acc(0, OP2_STAT, 0, 1, 32'h0800_009F);
    acc(1, OP2_STAT, 32'h0000_0000, 1, 32'h0000_0000);
    $display("test status mask done");
    for (int k = 0; k < 7; k++) begin
      p = (k == 6) ? SAT_POS : ((k == 5) ? DENORM_POS : k);
      i_dp.pulse(7'h01 << k);
      @(negedge mclk_i);
      acc(0, OP2_STAT, 0, 1, 32'h1 << p);
      acc(1, OP2_STAT, 32'h0000_0000, 1, 32'h0000_0000);
      acc(0, OP2_STAT, 0, 1, 32'h0000_0000);
    end
    $display("test sticky flags done");
    fork
      i_dp.pulse(7'h7F);
      acc(1, OP2_STAT, 32'h0000_0000, 1, 32'h0000_0000);
    join
    acc(0, OP2_STAT, 0, 1, 32'h0800_009F);
    acc(0, 3'h2, 0, 0, 32'h0000_0000);
    $display("test collision and decode done");
    reset_i = 1;
    @(negedge mclk_i);
    reset_i = 0;
    acc(0, OP2_STAT, 0, 1, STAT_RESET);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
